/* File: core/jdm_pkg.sv */
// Shared constants and types for the test/debug port front end.
// Assumes a single 100 MHz system clock samples every port pin.
package jdm_pkg;

    // ----------------------------------------------------------------
    // Synchroniser bit positions
    // ----------------------------------------------------------------
    localparam int SY_W = 5;
    localparam int SY_TCK = 0;
    localparam int SY_CLKRST = 1;
    localparam int SY_TMS = 2;
    localparam int SY_TDI = 3;
    localparam int SY_STRAP = 4;

    // ----------------------------------------------------------------
    // Scan controller
    // ----------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPT_PAT = 4'h1;
    localparam int BSR_LEN = 8;
    localparam int TMS_RESET_EDGES = 5;

    // ----------------------------------------------------------------
    // Debug serial link
    // ----------------------------------------------------------------
    localparam int DBG_W = 17;
    localparam int DEBUG_SERIAL_CLOCK_RATIO = 5;

    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SDR = 4'h3, ST_CDR = 4'h2,
        ST_SHDR = 4'h6, ST_E1DR = 4'h7, ST_PDR = 4'h5, ST_E2DR = 4'h4,
        ST_UDR = 4'hC, ST_SIR = 4'hD, ST_CIR = 4'hF, ST_SHIR = 4'hE,
        ST_E1IR = 4'hA, ST_PIR = 4'hB, ST_E2IR = 4'h9, ST_UIR = 4'h8
    } jdm_tap_state_t;

endpackage : jdm_pkg

/* File: core/jdm_tap.sv */
// Sixteen-state boundary-scan controller with IR, bypass and scan chain.
// Assumes test clock edges arrive as one-cycle pulses on ref_clk.
module jdm_tap
    import jdm_pkg::*;
#(
    parameter int BSR_W = BSR_LEN
) (
    input wire logic ref_clk,
    input wire logic tap_rst_n,
    input wire logic reset_n,
    jdm_tap_if.tap tif,
    input wire logic [BSR_W-1:0] bsr_capture,
    output logic [BSR_W-1:0] bsr_update,
    output logic extest_active
);

    initial begin
        if (BSR_W < 1) $error("BSR_W must be at least 1");
    end

    function automatic jdm_tap_state_t step(jdm_tap_state_t s, logic m);
        unique case (s)
            ST_TLR: step = m ? ST_TLR : ST_RTI;
            ST_RTI: step = m ? ST_SDR : ST_RTI;
            ST_SDR: step = m ? ST_SIR : ST_CDR;
            ST_CDR: step = m ? ST_E1DR : ST_SHDR;
            ST_SHDR: step = m ? ST_E1DR : ST_SHDR;
            ST_E1DR: step = m ? ST_UDR : ST_PDR;
            ST_PDR: step = m ? ST_E2DR : ST_PDR;
            ST_E2DR: step = m ? ST_UDR : ST_SHDR;
            ST_UDR: step = m ? ST_SDR : ST_RTI;
            ST_SIR: step = m ? ST_TLR : ST_CIR;
            ST_CIR: step = m ? ST_E1IR : ST_SHIR;
            ST_SHIR: step = m ? ST_E1IR : ST_SHIR;
            ST_E1IR: step = m ? ST_UIR : ST_PIR;
            ST_PIR: step = m ? ST_E2IR : ST_PIR;
            ST_E2IR: step = m ? ST_UIR : ST_SHIR;
            ST_UIR: step = m ? ST_SDR : ST_RTI;
        endcase
    endfunction

    jdm_tap_state_t state_ff, nxt_state;
    logic [IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
    logic byp_ff, nxt_byp, tdo_ff, nxt_tdo, oe_ff, nxt_oe;
    logic [BSR_W-1:0] bsr_sh_ff, nxt_bsr_sh, bsr_upd_ff, nxt_bsr_upd;
    logic sel_bsr;

    assign sel_bsr = (ir_ff == IR_EXTEST) || (ir_ff == IR_SAMPLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_ir_sh = ir_sh_ff;
        nxt_ir = ir_ff;
        nxt_byp = byp_ff;
        nxt_bsr_sh = bsr_sh_ff;
        nxt_bsr_upd = bsr_upd_ff;
        nxt_tdo = tdo_ff;
        nxt_oe = oe_ff;
        if (tif.tck_rise) begin
            nxt_state = step(state_ff, tif.tms);
            unique case (state_ff)
                ST_TLR: nxt_ir = IR_BYPASS;
                // Reset state reached by mode alone must drop the instruction
                ST_SIR: if (tif.tms) nxt_ir = IR_BYPASS;
                ST_CIR: nxt_ir_sh = IR_CAPT_PAT;
                ST_SHIR: nxt_ir_sh = {tif.tdi, ir_sh_ff[IR_W-1:1]};
                ST_UIR: nxt_ir = ir_sh_ff;
                ST_CDR: begin
                    if (sel_bsr) nxt_bsr_sh = bsr_capture;
                    else nxt_byp = 1'b0;
                end
                ST_SHDR: begin
                    if (sel_bsr) begin
                        nxt_bsr_sh = {tif.tdi, bsr_sh_ff[BSR_W-1:1]};
                    end else begin
                        nxt_byp = tif.tdi;
                    end
                end
                ST_UDR: if (sel_bsr) nxt_bsr_upd = bsr_sh_ff;
                default: ;
            endcase
        end
        if (tif.tck_fall) begin
            // Output follows the state reached at the last rising edge
            nxt_oe = (state_ff == ST_SHIR) || (state_ff == ST_SHDR);
            if (state_ff == ST_SHIR) nxt_tdo = ir_sh_ff[0];
            else if (sel_bsr) nxt_tdo = bsr_sh_ff[0];
            else nxt_tdo = byp_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_ff <= ST_TLR;
            ir_sh_ff <= IR_CAPT_PAT;
            ir_ff <= IR_BYPASS;
            byp_ff <= 1'b0;
            bsr_sh_ff <= '0;
            bsr_upd_ff <= '0;
            tdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ir_sh_ff <= nxt_ir_sh;
            ir_ff <= nxt_ir;
            byp_ff <= nxt_byp;
            bsr_sh_ff <= nxt_bsr_sh;
            bsr_upd_ff <= nxt_bsr_upd;
            tdo_ff <= nxt_tdo;
            oe_ff <= nxt_oe;
        end
    end

    assign tif.tdo = tdo_ff;
    assign tif.tdo_en = oe_ff;
    assign bsr_update = bsr_upd_ff;
    assign extest_active = (ir_ff == IR_EXTEST);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [2:0] tms_run_ff;
    always_ff @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) tms_run_ff <= '0;
        else if (tif.tck_rise && !tif.tms) tms_run_ff <= '0;
        else if (tif.tck_rise && tms_run_ff < 3'(TMS_RESET_EDGES))
            tms_run_ff <= tms_run_ff + 3'h1;
    end

    sequence s_cap_ir;
        tif.tck_rise && state_ff == ST_CIR;
    endsequence

    chk_trst_force: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !tap_rst_n |-> state_ff == ST_TLR)
        else $error("test reset did not force reset state");
    chk_tms_five: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
        tms_run_ff == 3'(TMS_RESET_EDGES) |-> state_ff == ST_TLR)
        else $error("five high mode edges did not reach reset state");
    chk_state_hold: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
        !tif.tck_rise |=> $stable(state_ff))
        else $error("controller moved without a test clock rise");
    chk_ir_capture: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
        s_cap_ir |=> ir_sh_ff == IR_CAPT_PAT)
        else $error("instruction capture pattern not loaded");
    chk_tdo_fall: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
        !$stable(tdo_ff) |-> $past(tif.tck_fall))
        else $error("test data out changed off a falling edge");
    chk_tdo_hiz: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
        $rose(oe_ff) |-> $past(state_ff == ST_SHIR || state_ff == ST_SHDR))
        else $error("test data out enabled outside shifting");

endmodule : jdm_tap

/* File: core/jdm_tap_if.sv */
// Link between the pin front end and the scan controller.
// Assumes both ends run on the same system clock.
interface jdm_tap_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_en;
    modport tap (input tck_rise, input tck_fall, input tms, input tdi,
                 output tdo, output tdo_en);
    modport ctl (output tck_rise, output tck_fall, output tms,
                 output tdi, input tdo, input tdo_en);
endinterface : jdm_tap_if

/* File: core/jdm_top.sv */
// Shared-pin front end: boundary-scan port or debug serial link.
// Assumes all pin inputs are asynchronous to ref_clk; pads resolve
// the data-out enable and the mode/breakpoint pull-up.
//
// Notes on behaviour
// - Strap high routes the pins to scan clock, mode, data in/out, reset.
// - Strap low routes the pins to debug clock, data in/out, breakpoint.
// - Test reset low forces the scan controller to reset state at once.
// - Five test clock rises with mode high reach the reset state.
// - A sixteen-state controller steps on each test clock rise by mode.
// - Test data in is captured into IR, bypass or chain on the rise.
// - Test data out is updated on the test clock fall.
// - Test data out floats whenever no shift is in progress.
// - In debug mode the breakpoint pin raises a core breakpoint request.
// - Debug commands are shifted in one bit at a time on serial input.
// - Debug responses are shifted out one bit at a time on serial out.
// - An undriven mode select reads as one, as if pulled up.
module jdm_top
    import jdm_pkg::*;
#(
    parameter int BSR_W = BSR_LEN,
    parameter int CMD_W = DBG_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic test_mode_strap,
    input wire logic clk_reset_pin,
    input wire logic tck_pin,
    input wire logic mode_breakpoint_request_pin,
    input wire logic mode_breakpoint_request_driven,
    input wire logic data_in_pin,
    output logic data_out_pin,
    output logic data_out_oe,
    output logic test_mode,
    output logic breakpoint_request,
    output logic dbg_cmd_valid,
    output logic [CMD_W-1:0] dbg_cmd_data,
    input wire logic [CMD_W-1:0] dbg_resp_data,
    input wire logic [BSR_W-1:0] bsr_capture,
    output logic [BSR_W-1:0] bsr_update,
    output logic extest_active
);

    localparam int CNT_W = $clog2(CMD_W + 1);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CMD_W - 1);

    initial begin
        if (CMD_W < 2) $error("CMD_W must be at least 2");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [SY_W-1:0] pins_raw, sy1_ff, sy2_ff, prev_ff;
    logic tap_rst_n;
    // Idle levels: mode pin sits at its pull-up, so no false breakpoint
    localparam logic [SY_W-1:0] SY_IDLE = SY_W'(1 << SY_TMS);

    // Pad pull-up stand-in: undriven mode pin reads high
    assign pins_raw = {test_mode_strap, data_in_pin,
                       mode_breakpoint_request_driven ? mode_breakpoint_request_pin : 1'b1,
                       clk_reset_pin, tck_pin};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sy1_ff <= SY_IDLE;
            sy2_ff <= SY_IDLE;
            prev_ff <= SY_IDLE;
        end else begin
            sy1_ff <= pins_raw;
            sy2_ff <= sy1_ff;
            prev_ff <= sy2_ff;
        end
    end

    // Test reset bypasses the synchroniser so it acts without any edge
    assign tap_rst_n = reset_n & clk_reset_pin;

    logic test_sel, tck_rise, tck_fall, ds_rise;
    assign test_sel = sy2_ff[SY_STRAP];
    assign tck_rise = sy2_ff[SY_TCK] & ~prev_ff[SY_TCK];
    assign tck_fall = ~sy2_ff[SY_TCK] & prev_ff[SY_TCK];
    // Relies on the debug clock being slow enough to see each level
    assign ds_rise = sy2_ff[SY_CLKRST] & ~prev_ff[SY_CLKRST];

    // ----------------------------------------------------------------
    // Scan controller
    // ----------------------------------------------------------------
    jdm_tap_if tif ();

    assign tif.tck_rise = test_sel & tck_rise;
    assign tif.tck_fall = test_sel & tck_fall;
    assign tif.tms = sy2_ff[SY_TMS];
    assign tif.tdi = sy2_ff[SY_TDI];

    jdm_tap #(.BSR_W(BSR_W)) u_tap (
        .ref_clk(ref_clk),
        .tap_rst_n(tap_rst_n),
        .reset_n(reset_n),
        .tif(tif),
        .bsr_capture(bsr_capture),
        .bsr_update(bsr_update),
        .extest_active(extest_active)
    );

    // ----------------------------------------------------------------
    // Debug serial link
    // ----------------------------------------------------------------
    logic [CMD_W-1:0] cmd_sh_ff, nxt_cmd_sh, resp_sh_ff, nxt_resp_sh;
    logic [CMD_W-1:0] cmd_data_ff, nxt_cmd_data;
    logic [CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
    logic cmd_valid_ff, nxt_cmd_valid, dso_ff, nxt_dso;
    logic breakpoint_request_ff, nxt_breakpoint_request;

    always_comb begin
        nxt_cmd_sh = cmd_sh_ff;
        nxt_resp_sh = resp_sh_ff;
        nxt_cmd_data = cmd_data_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_cmd_valid = 1'b0;
        nxt_dso = dso_ff;
        nxt_breakpoint_request = ~test_sel & ~sy2_ff[SY_TMS];
        if (test_sel) begin
            // Frame position is lost on a switch to scan mode
            nxt_bit_cnt = '0;
        end else if (ds_rise) begin
            nxt_cmd_sh = {cmd_sh_ff[CMD_W-2:0], sy2_ff[SY_TDI]};
            nxt_resp_sh = {resp_sh_ff[CMD_W-2:0], 1'b0};
            if (bit_cnt_ff == LAST_BIT) begin
                nxt_cmd_data = {cmd_sh_ff[CMD_W-2:0], sy2_ff[SY_TDI]};
                nxt_cmd_valid = 1'b1;
                nxt_bit_cnt = '0;
                nxt_resp_sh = dbg_resp_data;
            end else begin
                nxt_bit_cnt = bit_cnt_ff + CNT_W'(1);
            end
            nxt_dso = nxt_resp_sh[CMD_W-1];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_sh_ff <= '0;
            resp_sh_ff <= '0;
            cmd_data_ff <= '0;
            bit_cnt_ff <= '0;
            cmd_valid_ff <= 1'b0;
            dso_ff <= 1'b0;
            breakpoint_request_ff <= 1'b0;
        end else begin
            cmd_sh_ff <= nxt_cmd_sh;
            resp_sh_ff <= nxt_resp_sh;
            cmd_data_ff <= nxt_cmd_data;
            bit_cnt_ff <= nxt_bit_cnt;
            cmd_valid_ff <= nxt_cmd_valid;
            dso_ff <= nxt_dso;
            breakpoint_request_ff <= nxt_breakpoint_request;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign data_out_pin = test_sel ? tif.tdo : dso_ff;
    assign data_out_oe = test_sel ? tif.tdo_en : 1'b1;
    assign test_mode = test_sel;
    assign breakpoint_request = breakpoint_request_ff;
    assign dbg_cmd_valid = cmd_valid_ff;
    assign dbg_cmd_data = cmd_data_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_ds_edge;
        !sy2_ff[SY_CLKRST] ##1 sy2_ff[SY_CLKRST];
    endsequence

    chk_route_scan: assert property (@(posedge ref_clk) disable iff (!reset_n)
        test_sel |-> data_out_pin == tif.tdo ##1 !breakpoint_request)
        else $error("scan mode pins not routed to controller");
    chk_route_debug: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !test_sel |-> data_out_oe && data_out_pin == dso_ff)
        else $error("debug mode output not driven");
    chk_breakpoint_request_raise: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !test_sel && !sy2_ff[SY_TMS] |=> breakpoint_request)
        else $error("breakpoint pin did not raise request");
    chk_dbg_frame: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dbg_cmd_valid |-> $past(ds_rise) && $past(bit_cnt_ff) == LAST_BIT
        && dbg_cmd_data[0] == $past(sy2_ff[SY_TDI]))
        else $error("command word not closed on its last bit");
    chk_resp_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dbg_cmd_valid |-> dso_ff == $past(dbg_resp_data[CMD_W-1]))
        else $error("response first bit not presented");
    chk_edge_sync: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_ds_edge ##0 !test_sel |=> cmd_sh_ff[0] == $past(sy2_ff[SY_TDI]))
        else $error("debug clock rise did not shift a bit");

    // ----------------------------------------------------------------
    // Link-level checks
    // ----------------------------------------------------------------
    // Response pin must hold between rises or the host misreads it
    sequence s_no_rise;
        !ds_rise || test_sel;
    endsequence

    sequence s_word_done;
        dbg_cmd_valid;
    endsequence

    chk_dso_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_no_rise |=> $stable(dso_ff))
        else $error("debug serial out moved without a clock rise");
    chk_cmd_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_word_done |=> !dbg_cmd_valid)
        else $error("command valid held longer than one cycle");
    chk_breakpoint_request_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sy2_ff[SY_TMS] |=> !breakpoint_request)
        else $error("breakpoint request stayed up after release");
    chk_frame_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
        test_sel |=> bit_cnt_ff == '0)
        else $error("frame position kept across scan mode");

endmodule : jdm_top

/* File: dv/jdm_probe.sv */
// Behavioural scan tester and debug probe on the shared pins.
// Assumes ref_clk is the bench clock; pins move on its falling edge.
module jdm_probe (
    input wire logic ref_clk,
    output logic clk_reset_pin,
    output logic tck_pin,
    output logic mode_breakpoint_request_pin,
    output logic mode_breakpoint_request_driven,
    output logic data_in_pin,
    input wire logic data_out_pin,
    input wire logic data_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // 160 ns link clock: eight ref_clk cycles per phase
    localparam int HALF = 8;

    initial begin
        clk_reset_pin = 1'b0;
        tck_pin = 1'b0;
        mode_breakpoint_request_pin = 1'b0;
        mode_breakpoint_request_driven = 1'b0;
        data_in_pin = 1'b1;
    end

    // --------------------------------------------------------------
    // Debug link: clock idles low between bits
    // --------------------------------------------------------------
    task automatic dbg_bit(input logic b, output logic so);
        @(negedge ref_clk);
        so = data_out_pin;
        data_in_pin = b;
        clk_reset_pin = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        clk_reset_pin = 1'b0;
        repeat (HALF) @(negedge ref_clk);
        // Hold time over: show the inverse so stale data is never seen
        data_in_pin = ~b;
    endtask

    // --------------------------------------------------------------
    // Scan link: one full test clock, pu leaves mode to the pull-up
    // --------------------------------------------------------------
    task automatic tclk(input logic tms, input logic tdi, input logic pu,
                        output logic tdo, output logic oe);
        @(negedge ref_clk);
        mode_breakpoint_request_driven = ~pu;
        mode_breakpoint_request_pin = pu ? 1'b0 : tms;
        data_in_pin = tdi;
        tck_pin = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        tck_pin = 1'b0;
        repeat (HALF) @(negedge ref_clk);
        tdo = data_out_pin;
        oe = data_out_oe;
    endtask

    task automatic drive_mode(input logic drv, input logic lvl);
        @(negedge ref_clk);
        mode_breakpoint_request_driven = drv;
        mode_breakpoint_request_pin = lvl;
    endtask

    task automatic trst(input logic lvl);
        @(negedge ref_clk);
        clk_reset_pin = lvl;
    endtask
endmodule // jdm_probe

/* File: dv/tb_top.sv */
// Self-checking bench for the shared-pin test and debug front end.
// Assumes jdm_probe plays the far side; all pins are asynchronous.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BSR_W = 8;
    localparam int CMD_W = 17;
    localparam logic [16:0] CMD1 = 17'h1_A5C3;
    localparam logic [16:0] CMD2 = 17'h0_5A3C;
    localparam logic [16:0] RESP1 = 17'h0_F00D;
    localparam logic [16:0] RESP2 = 17'h1_0F0F;

    logic ref_clk, reset_n, test_mode_strap;
    logic clk_reset_pin, tck_pin, mode_breakpoint_request_pin, mode_breakpoint_request_driven;
    logic data_in_pin, data_out_pin, data_out_oe, test_mode;
    logic breakpoint_request, dbg_cmd_valid, extest_active;
    logic [CMD_W-1:0] dbg_cmd_data, dbg_resp_data;
    logic [BSR_W-1:0] bsr_capture, bsr_update;
    wire tdo_wire;
    int n_mismatch = 0;
    int checked = 0;
    int n_pulse = 0;

    // Released data out shows the inverse, so a stale bit is never read
    assign tdo_wire = data_out_oe ? data_out_pin : ~data_out_pin;

    jdm_top #(.BSR_W(BSR_W), .CMD_W(CMD_W)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .test_mode_strap(test_mode_strap), .clk_reset_pin(clk_reset_pin),
        .tck_pin(tck_pin), .mode_breakpoint_request_pin(mode_breakpoint_request_pin),
        .mode_breakpoint_request_driven(mode_breakpoint_request_driven), .data_in_pin(data_in_pin),
        .data_out_pin(data_out_pin), .data_out_oe(data_out_oe),
        .test_mode(test_mode), .breakpoint_request(breakpoint_request),
        .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_data(dbg_cmd_data),
        .dbg_resp_data(dbg_resp_data), .bsr_capture(bsr_capture),
        .bsr_update(bsr_update), .extest_active(extest_active)
    );

    jdm_probe probe_u (
        .ref_clk(ref_clk), .clk_reset_pin(clk_reset_pin),
        .tck_pin(tck_pin), .mode_breakpoint_request_pin(mode_breakpoint_request_pin),
        .mode_breakpoint_request_driven(mode_breakpoint_request_driven), .data_in_pin(data_in_pin),
        .data_out_pin(tdo_wire), .data_out_oe(data_out_oe)
    );

    always #5 ref_clk = ~ref_clk;

    // Counting high cycles also catches a pulse that lasts too long
    always @(posedge ref_clk) begin
        if (dbg_cmd_valid === 1'b1) begin
            n_pulse++;
        end
    end

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic settle;
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic scan(input bit ir, input logic [7:0] din, input int n,
                        output logic [7:0] dout);
        logic tdo, oe;
        dout = 8'h00;
        probe_u.tclk(1'b1, 1'b1, 1'b0, tdo, oe);
        if (ir) probe_u.tclk(1'b1, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        dout[0] = tdo;
        chk(17'(oe), 17'h0_0001, "oe while shifting");
        for (int i = 0; i < n; i++) begin
            probe_u.tclk(i == n - 1, din[i], 1'b0, tdo, oe);
            if (i < n - 1) dout[i + 1] = tdo;
        end
        chk(17'(oe), 17'h0_0000, "oe after shift");
        probe_u.tclk(1'b1, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_debug;
        logic so;
        int p;
        settle;
        chk(17'(test_mode), 17'h0_0000, "debug mode");
        dbg_resp_data = RESP1;
        p = n_pulse;
        for (int i = 16; i >= 0; i--) probe_u.dbg_bit(CMD1[i], so);
        settle;
        chk(17'(n_pulse - p), 17'h0_0001, "pulse one");
        chk(dbg_cmd_data, CMD1, "first word");
        dbg_resp_data = RESP2;
        p = n_pulse;
        for (int i = 16; i >= 0; i--) begin
            probe_u.dbg_bit(CMD2[i], so);
            chk(17'(so), 17'(RESP1[i]), "response bit");
        end
        settle;
        chk(17'(n_pulse - p), 17'h0_0001, "pulse two");
        chk(dbg_cmd_data, CMD2, "second word");
        chk(17'(data_out_pin), 17'(RESP2[16]), "next msb");
        chk(17'(data_out_oe), 17'h0_0001, "debug out on");
    endtask

    task automatic t_breakpoint_request;
        probe_u.drive_mode(1'b1, 1'b0);
        settle;
        chk(17'(breakpoint_request), 17'h0_0001, "breakpoint_request set");
        probe_u.drive_mode(1'b0, 1'b0);
        settle;
        chk(17'(breakpoint_request), 17'h0_0000, "breakpoint_request pull-up");
        test_mode_strap = 1'b1;
        probe_u.drive_mode(1'b1, 1'b0);
        settle;
        chk(17'(breakpoint_request), 17'h0_0000, "no breakpoint_request in scan");
        chk(17'(test_mode), 17'h0_0001, "scan mode");
    endtask

    task automatic t_scan;
        logic [7:0] d;
        logic tdo, oe;
        probe_u.trst(1'b1);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        chk(17'(oe), 17'h0_0000, "idle float");
        scan(1'b0, 8'h01, 2, d);
        chk(17'(d[1:0]), 17'h0_0002, "bypass");
        scan(1'b1, 8'h00, 4, d);
        chk(17'(d[3:0]), 17'(jdm_pkg::IR_CAPT_PAT), "ir capture");
        chk(17'(extest_active), 17'h0_0001, "ir load");
        bsr_capture = 8'hC6;
        scan(1'b0, 8'h5A, 8, d);
        chk(17'(d), 17'h0_00C6, "chain out");
        chk(17'(bsr_update), 17'h0_005A, "chain update");
        probe_u.tclk(1'b1, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        for (int i = 0; i < 5; i++) begin
            chk(17'(extest_active), 17'h0_0001, "not yet reset");
            probe_u.tclk(1'b1, 1'b0, 1'b1, tdo, oe);
        end
        chk(17'(extest_active), 17'h0_0000, "five clocks");
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        scan(1'b1, 8'h00, 4, d);
        probe_u.tclk(1'b1, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        probe_u.tclk(1'b0, 1'b1, 1'b0, tdo, oe);
        chk(17'(oe), 17'h0_0001, "shift oe");
        probe_u.trst(1'b0);
        repeat (2) @(negedge ref_clk);
        chk(17'(data_out_oe), 17'h0_0000, "trst oe");
        chk(17'(extest_active), 17'h0_0000, "trst ir");
        chk(17'(bsr_update), 17'h0_0000, "trst chain");
        probe_u.trst(1'b1);
    endtask

    task summarize;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; this leaves wide margin
    initial begin
        #200us;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        summarize;
    end

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        test_mode_strap = 1'b0;
        dbg_resp_data = 17'h0_0000;
        bsr_capture = 8'h00;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_debug;
        t_breakpoint_request;
        t_scan;
        summarize;
    end
endmodule // tb_top
